// *** hdl/dio_ctrl.sv ***
// Controller end: issues start and stop, reads back the result
`timescale 1ns/100ps
module dio_ctrl
  import dio_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic START_IN,
  input wire logic STOP_IN,
  input wire logic [7:0] RUN_LENGTH_IN,
  output logic [15:0] RESULT_OUT,
  output logic OVERFLOW_OUT,
  output logic BUSY_OUT,
  dio_link_if.ctrl LINK
);
  typedef struct packed {
    logic [3:0] div;
    logic lclk;
    logic cmd_valid;
    logic [6:0] cmd_op;
    logic [7:0] run_length;
    logic busy;
    logic start_pend;
    logic stop_pend;
    logic [7:0] min_cnt;
    logic [11:0] auto_cnt;
    logic [15:0] result;
    logic overflow;
  } dio_ctl_t;
  dio_ctl_t r;
  dio_ctl_t next_r;
  logic fall;
  logic [11:0] auto_limit;
  always_comb begin
    next_r = r;
    fall = 1'b0;
    auto_limit = 12'(r.run_length) * 12'(DIO_RUN_STEP);
    if (r.div == DIO_DIV_MAX) begin
      next_r.div = DIO_DIV_RST;
      next_r.lclk = ~r.lclk;
      fall = r.lclk;
    end else begin
      next_r.div = r.div + 4'h1;
    end
    if (START_IN && !r.busy) begin
      next_r.start_pend = 1'b1;
    end
    if (STOP_IN && r.busy && r.run_length == DIO_RUNLEN_RST) begin
      next_r.stop_pend = 1'b1;
    end
    if (r.busy && r.min_cnt < 8'(DIO_MIN_RUN_CYC)) begin
      next_r.min_cnt = r.min_cnt + 8'h01;
    end
    if (fall) begin
      next_r.cmd_valid = 1'b0;
      if (r.start_pend) begin
        next_r.cmd_valid = 1'b1;
        next_r.cmd_op = DIO_OP_START;
        next_r.run_length = RUN_LENGTH_IN;
        next_r.start_pend = 1'b0;
        next_r.busy = 1'b1;
        next_r.min_cnt = 8'h00;
        next_r.auto_cnt = 12'h000;
      end else if (r.stop_pend && r.min_cnt >= 8'(DIO_MIN_RUN_CYC)) begin
        next_r.cmd_valid = 1'b1;
        next_r.cmd_op = DIO_OP_STOP;
        next_r.stop_pend = 1'b0;
      end else if (r.busy && r.run_length != DIO_RUNLEN_RST) begin
        // Device copies results before this fall
        if (r.auto_cnt == auto_limit) begin
          next_r.busy = 1'b0;
        end else begin
          next_r.auto_cnt = r.auto_cnt + 12'h001;
        end
      end
    end
    if (r.busy && LINK.result_valid && r.min_cnt >= 8'(DIO_MIN_RUN_CYC) && !r.cmd_valid) begin
      next_r.result = {LINK.count_high, LINK.count_low};
      next_r.overflow = ({LINK.count_high, LINK.count_low} == DIO_CNT_MAX);
    end
    if (r.busy && !r.start_pend && r.cmd_op == DIO_OP_STOP && !r.cmd_valid && !r.stop_pend) begin
      next_r.busy = 1'b0;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      r <= '{div: DIO_DIV_RST, lclk: 1'b0, cmd_valid: 1'b0, cmd_op: 7'h00,
        run_length: DIO_RUNLEN_RST, busy: 1'b0, start_pend: 1'b0, stop_pend: 1'b0,
        min_cnt: 8'h00, auto_cnt: 12'h000, result: DIO_CNT_RST, overflow: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign LINK.link_clk = r.lclk;
  assign LINK.cmd_valid = r.cmd_valid;
  assign LINK.cmd_op = r.cmd_op;
  assign LINK.run_length = r.run_length;
  assign RESULT_OUT = r.result;
  assign OVERFLOW_OUT = r.overflow;
  assign BUSY_OUT = r.busy;
endmodule // dio_ctrl

// *** hdl/dio_device.sv ***
// Device end: oscillator counter and result registers for one channel
// Summary of operation
// - Start command launches ring oscillator counting
// - Run ends by stop or auto count
// - No stop command under auto stop
// - End of run copies counter to results
// - Count 16 bits, low and high bytes
// - Stop overwrites both result registers
// - Counter saturates at maximum
// - Controller keeps maximum and flags it as overflow
// - Result counts replica delays in run
// - Runs last at least 200 ns
// - Longer runs, but below overflow
// - Operands 1001011 start, 1001101 stop
// - Start and stop need no follow-up
`timescale 1ns/100ps
module dio_device
  import dio_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic OSC_TICK_IN,
  dio_link_if.dev LINK
);
  typedef struct packed {
    dio_state_t state;
    logic [2:0] lclk_sync;
    logic [1:0] tick_sync;
    logic tick_prev;
    logic [15:0] count;
    logic [11:0] run_clks;
    logic auto_mode;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic result_valid;
  } dio_dev_t;
  dio_dev_t r;
  dio_dev_t next_r;
  logic lclk_rise;
  logic tick_rise;
  logic [11:0] run_limit;
  logic take;
  always_comb begin
    next_r = r;
    next_r.lclk_sync = {r.lclk_sync[1:0], LINK.link_clk};
    next_r.tick_sync = {r.tick_sync[0], OSC_TICK_IN};
    next_r.tick_prev = r.tick_sync[1];
    // Edge found only after two sync stages
    lclk_rise = r.lclk_sync[1] & ~r.lclk_sync[2];
    tick_rise = r.tick_sync[1] & ~r.tick_prev;
    run_limit = 12'(LINK.run_length) * 12'(DIO_RUN_STEP);
    take = lclk_rise & LINK.cmd_valid;
    case (r.state)
      DIO_IDLE: begin
        if (take && LINK.cmd_op == DIO_OP_START) begin
          next_r.state = DIO_RUN;
          next_r.count = DIO_CNT_RST;
          next_r.run_clks = 12'h000;
          next_r.auto_mode = (LINK.run_length != DIO_RUNLEN_RST);
        end
      end
      DIO_RUN: begin
        if (tick_rise && r.count != DIO_CNT_MAX) begin
          next_r.count = r.count + 16'h0001;
        end
        if (lclk_rise) begin
          next_r.run_clks = r.run_clks + 12'h001;
        end
        if ((take && LINK.cmd_op == DIO_OP_STOP && !r.auto_mode) ||
            (r.auto_mode && lclk_rise && next_r.run_clks >= run_limit)) begin
          next_r.state = DIO_IDLE;
          next_r.count_low = next_r.count[7:0];
          next_r.count_high = next_r.count[15:8];
          next_r.result_valid = 1'b1;
        end
      end
      default: next_r.state = DIO_IDLE;
    endcase
  end
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      r <= '{state: DIO_IDLE, lclk_sync: 3'h0, tick_sync: 2'h0, tick_prev: 1'b0,
        count: DIO_CNT_RST, run_clks: 12'h000, auto_mode: 1'b0, count_low: DIO_RES_RST,
        count_high: DIO_RES_RST, result_valid: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign LINK.count_low = r.count_low;
  assign LINK.count_high = r.count_high;
  assign LINK.result_valid = r.result_valid;
endmodule // dio_device

// *** hdl/dio_link_if.sv ***
// Interface joining controller and device ends of the oscillator link
`timescale 1ns/100ps
interface dio_link_if;
  logic link_clk;
  logic cmd_valid;
  logic [6:0] cmd_op;
  logic [7:0] run_length;
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic result_valid;
  modport ctrl (output link_clk, output cmd_valid, output cmd_op, output run_length,
    input count_low, input count_high, input result_valid);
  modport dev (input link_clk, input cmd_valid, input cmd_op, input run_length,
    output count_low, output count_high, output result_valid);
endinterface // dio_link_if

// *** hdl/dio_pkg.sv ***
// Package with constants and types for the interval oscillator link
package dio_pkg;
  localparam int DIO_OP_W = 7;
  localparam logic [6:0] DIO_OP_START = 7'h4b;
  localparam logic [6:0] DIO_OP_STOP = 7'h4d;
  localparam int DIO_CNT_W = 16;
  localparam logic [15:0] DIO_CNT_MAX = 16'hffff;
  localparam logic [15:0] DIO_CNT_RST = 16'h0000;
  localparam logic [7:0] DIO_RUNLEN_RST = 8'h00;
  localparam logic [7:0] DIO_RES_RST = 8'h00;
  localparam int DIO_MIN_RUN_NS = 200;
  localparam int DIO_CLK_NS = 100;
  localparam int DIO_MIN_RUN_CYC = (DIO_MIN_RUN_NS + DIO_CLK_NS - 1) / DIO_CLK_NS;
  localparam int DIO_RUN_STEP = 16;
  localparam logic [3:0] DIO_DIV_RST = 4'h0;
  localparam logic [3:0] DIO_DIV_MAX = 4'h3;
  typedef enum logic [1:0] {DIO_IDLE, DIO_RUN} dio_state_t;
endpackage

// *** tb/dio_link_props.sv ***
// Link protocol assertions for the interval oscillator
`timescale 1ns/100ps
module dio_link_props
  import dio_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire logic [6:0] cmd_op,
  input wire logic [7:0] run_length,
  input wire logic [7:0] count_low,
  input wire logic [7:0] count_high,
  input wire logic result_valid
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  a_op_legal: assert property (cmd_valid |-> cmd_op == DIO_OP_START || cmd_op == DIO_OP_STOP)
    else $error("illegal operand");
  a_no_auto_stop: assert property (cmd_valid && cmd_op == DIO_OP_STOP |-> run_length == 8'h00)
    else $error("stop sent in auto mode");
  a_cmd_standalone: assert property ($rose(cmd_valid) |-> cmd_valid [*8] ##1 !cmd_valid)
    else $error("command length wrong");
  a_link_high: assert property ($rose(link_clk) |-> link_clk [*4] ##1 !link_clk)
    else $error("link clock high phase");
  a_link_low: assert property ($fell(link_clk) |-> !link_clk [*4] ##1 link_clk)
    else $error("link clock low phase");
  a_result_sticky: assert property (result_valid |=> result_valid)
    else $error("result flag dropped");
  a_result_flag: assert property ($changed({count_high, count_low}) |-> ##[0:1] result_valid)
    else $error("result without flag");
  a_reset_clear: assert property ($rose(RST_N_IN) |-> {count_high, count_low} == DIO_CNT_RST)
    else $error("result not cleared");
endmodule // dio_link_props

// *** tb/test_dio_interval_oscillator.sv ***
// Self-checking bench for both ends of the oscillator link
`timescale 1ns/100ps
module test_dio_interval_oscillator;
  import dio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic tick = 1'b0;
  logic [7:0] run_len = 8'h00;
  logic [15:0] result;
  logic overflow;
  logic busy;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  dio_link_if link();
  dio_ctrl u_dio_ctrl(.CLK_IN(clk), .RST_N_IN(rst_n), .START_IN(start), .STOP_IN(stop), .RUN_LENGTH_IN(run_len),
    .RESULT_OUT(result), .OVERFLOW_OUT(overflow), .BUSY_OUT(busy), .LINK(link.ctrl));
  dio_device u_dio_device(.CLK_IN(clk), .RST_N_IN(rst_n), .OSC_TICK_IN(tick), .LINK(link.dev));
  dio_link_props u_dio_link_props(.CLK_IN(clk), .RST_N_IN(rst_n), .link_clk(link.link_clk),
    .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .run_length(link.run_length), .count_low(link.count_low),
    .count_high(link.count_high), .result_valid(link.result_valid));
  always #50 clk = ~clk;
  // Hang guard well above the three runs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(string name, logic [16:0] exp, logic [16:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Ticks spaced 4 clocks so the synchronizer sees each one
  task automatic run(logic [7:0] len, int n);
    @(posedge clk);
    run_len <= len;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (20) @(posedge clk);
    repeat (n) begin
      repeat (2) @(posedge clk);
      tick <= 1'b1;
      repeat (2) @(posedge clk);
      tick <= 1'b0;
    end
    // Manual stop; must be refused in auto mode
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("result", {1'b0, n[15:0]}, {overflow, result});
    chk("bytes", {1'b0, n[15:0]}, {1'b0, link.count_high, link.count_low});
  endtask
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset", 17'h00000, {overflow, result});
    run(8'h00, 37);
    run(8'h00, 5);
    run(8'h01, 20);
    finish_test();
  end
endmodule // test_dio_interval_oscillator
